// File: periodic_realtime_counter.sv
/*
 * Periodic real-time counter: clock source select, binary/decimal
 * prescaler, 8-bit up-counter with modulo match and match interrupt,
 * reached over an AHB-Lite slave.
 * Assumes the three source clocks arrive as levels synchronous to hclk
 * and that the power-mode inputs come from the system controller.
 */
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - 8-bit up-counter compared to 8-bit modulo gives a periodic interrupt.
// - Clock select 00 low-power osc, 01 external ref, 1x internal ref.
// - Writing a changed clock select or prescale code clears both counters.
// - Divide ratio from prescale code and select bit 0; code 0 is off.
// - Select bit 0 low: codes map to 8..1024, 1,2,4,10,16,100,500,1000.
// - Match flag sets when count reached modulo; reset clears it.
// - Flag sets on the step from modulo value back to zero.
// - Writing 1 clears the flag and request; writing 0 does nothing.
// - Interrupt requested while flag and enable are set; reset clears enable.
// - Count register is read-only, live, ignores writes, resets to zero.
// - On match the counter returns to zero, keeps counting, sets flag.
// - Modulo zero sets the flag on every prescaler output edge.
// - Any modulo write clears prescaler and counter; modulo resets to zero.
// - Reset clears clock select and prescale code: oscillator, prescaler off.
// - Counting continues in wait mode so the interrupt can wake the core.
// - Counting continues in stop; only the oscillator runs in deep stop.
// - Debug mode freezes prescaler and counter; resume from held values.
module periodic_realtime_counter (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        low_power_osc_1khz,
    input  wire logic        external_ref_clock,
    input  wire logic        internal_ref_clock,
    input  wire logic        deep_stop_mode,
    input  wire logic        background_mode,
    output logic             rt_irq
);
    import rtc_pkg::*;

    // Control and status state
    logic               rt_match_flag;
    logic [1:0]         rt_clock_select;
    logic               rt_irq_enable;
    logic [3:0]         rt_prescale_select;
    logic [7:0]         rt_count_value;
    logic [7:0]         rt_modulo_limit;

    // Bus data-phase state
    logic               wr_pending;
    logic [7:0]         wr_offset;

    // Decoded write strobes, valid in the write data phase
    logic               wr_sc;
    logic               wr_cnt;
    logic               wr_mod;
    logic               cfg_change;
    logic               restart;
    logic               match_event;
    logic               flag_clear;

    // Source edge detection
    logic [2:0]         src_prev;
    logic               src_level;
    logic               src_prev_sel;
    logic               src_alive;

    presc_if pif ();

    rtc_prescaler u_prescaler (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pif     (pif)
    );

    // Register read mux, unmapped offsets read as zero
    function automatic logic [31:0] read_reg(input logic [7:0] ofs,
                                             input logic [7:0] sc,
                                             input logic [7:0] cnt,
                                             input logic [7:0] md);
        logic [31:0] d;
        d = '0;
        if (ofs == OFS_STATUS_CONTROL) begin
            d = {24'h000000, sc};
        end else if (ofs == OFS_COUNT_VALUE) begin
            d = {24'h000000, cnt};
        end else if (ofs == OFS_MODULO_LIMIT) begin
            d = {24'h000000, md};
        end
        return d;
    endfunction

    // The slave never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase: latch writes for the data phase, sample reads now
    // so that hrdata comes from a flop with no wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_offset  <= 8'h00;
        end else if (hready) begin
            wr_pending <= hsel && htrans == HTRANS_NONSEQ && hwrite
                          && hsize == HSIZE_WORD;
            wr_offset  <= haddr[7:0];
        end
    end

    // Read data sampled at the address phase edge. Limitation: a read
    // pipelined straight behind a write sees the value before that write
    // Read data sampled at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (hready && hsel && htrans == HTRANS_NONSEQ
                     && !hwrite) begin
            hrdata <= read_reg(haddr[7:0],
                {rt_match_flag, rt_clock_select, rt_irq_enable,
                 rt_prescale_select},
                rt_count_value, rt_modulo_limit);
        end
    end

    // Write strobes; the count register decodes but stores nothing
    always_comb begin
        wr_sc  = 1'b0;
        wr_cnt = 1'b0;
        wr_mod = 1'b0;
        if (!wr_pending) begin
            wr_sc = 1'b0;
        end else if (wr_offset == OFS_STATUS_CONTROL) begin
            wr_sc = 1'b1;
        end else if (wr_offset == OFS_COUNT_VALUE) begin
            wr_cnt = 1'b1;
        end else if (wr_offset == OFS_MODULO_LIMIT) begin
            wr_mod = 1'b1;
        end
    end

    // A status write restarts the chain only if a select value differs; a modulo write always does
    assign cfg_change = wr_sc &&
        (hwdata[CLKS_MSB:CLKS_LSB] != rt_clock_select ||
         hwdata[PS_MSB:PS_LSB] != rt_prescale_select);
    assign restart    = cfg_change || wr_mod;
    assign flag_clear = wr_sc && hwdata[FLAG_BIT];

    // Configuration fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_clock_select    <= CLKS_RESET;
            rt_prescale_select <= PS_RESET;
            rt_irq_enable      <= 1'b0;
        end else if (wr_sc) begin
            rt_clock_select    <= hwdata[CLKS_MSB:CLKS_LSB];
            rt_prescale_select <= hwdata[PS_MSB:PS_LSB];
            rt_irq_enable      <= hwdata[IE_BIT];
        end
    end

    // Modulo limit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_modulo_limit <= MODULO_RESET;
        end else if (wr_mod) begin
            rt_modulo_limit <= hwdata[7:0];
        end
    end

    // Previous sample of each source, for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_prev <= 3'h0;
        end else begin
            src_prev <= {internal_ref_clock, external_ref_clock,
                         low_power_osc_1khz};
        end
    end

    // Source mux
    always_comb begin
        if (rt_clock_select == CLKS_LPO) begin
            src_level    = low_power_osc_1khz;
            src_prev_sel = src_prev[0];
        end else if (rt_clock_select == CLKS_EXT) begin
            src_level    = external_ref_clock;
            src_prev_sel = src_prev[1];
        end else begin
            src_level    = internal_ref_clock;
            src_prev_sel = src_prev[2];
        end
    end

    // Deep stop powers down the reference clocks; the oscillator
    // keeps going, so stop and wait modes need no other gating
    assign src_alive = !deep_stop_mode
                       || rt_clock_select == CLKS_LPO;

    // Prescaler hookup
    assign pif.src_edge = src_level && !src_prev_sel && src_alive;
    assign pif.ratio    = divide_ratio(rt_clock_select[0],
                                       rt_prescale_select);
    assign pif.clear    = restart;
    assign pif.hold     = background_mode;

    // A match is a prescaler edge while the count sits on the limit
    assign match_event = pif.tick && !restart
                         && rt_count_value == rt_modulo_limit;

    // Counter; a restart wins over a tick in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_count_value <= COUNT_RESET;
        end else if (restart) begin
            rt_count_value <= COUNT_RESET;
        end else if (match_event) begin
            rt_count_value <= COUNT_RESET;
        end else if (pif.tick) begin
            rt_count_value <= rt_count_value + 8'h01;
        end
    end

    // Match flag; a new match wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_match_flag <= 1'b0;
        end else if (match_event) begin
            rt_match_flag <= 1'b1;
        end else if (flag_clear) begin
            rt_match_flag <= 1'b0;
        end
    end

    // Level request; also the wake source in wait and stop
    assign rt_irq = rt_match_flag && rt_irq_enable;

    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Flag rises only out of a wrap from the limit
    flag_rise_cause_a: assert property ($rose(rt_match_flag)
        |-> $past(pif.tick) && $past(rt_count_value) ==
            $past(rt_modulo_limit) && rt_count_value == 8'h00)
        else $error("flag rose without a modulo wrap");

    // Wrap goes to zero and flags it
    wrap_to_zero_a: assert property (match_event
        |=> rt_count_value == 8'h00 && rt_match_flag)
        else $error("match did not wrap to zero with flag");

    // Ordinary tick counts up by one
    count_step_a: assert property (pif.tick && !restart
        && rt_count_value != rt_modulo_limit
        |=> rt_count_value == $past(rt_count_value) + 8'h01)
        else $error("count did not step by one");

    // Zero limit flags on every prescaler edge
    zero_mod_flag_a: assert property (pif.tick && !restart
        && rt_modulo_limit == 8'h00 |=> rt_match_flag)
        else $error("zero modulo missed a flag");

    // Modulo write restarts the count
    mod_write_clr_a: assert property (wr_mod
        |=> rt_count_value == 8'h00 && rt_modulo_limit ==
            $past(hwdata[7:0]))
        else $error("modulo write did not restart");

    // Changed selection restarts the count
    sel_change_clr_a: assert property (cfg_change
        |=> rt_count_value == 8'h00)
        else $error("config change did not clear count");

    // Rewriting the same selection leaves the count running
    same_sel_keep_a: assert property (wr_sc && !cfg_change
        && !pif.tick |=> $stable(rt_count_value))
        else $error("unchanged config disturbed count");

    // Debug freeze holds the count for several cycles
    debug_freeze_a: assert property ((background_mode && !restart)
        [*3] |=> $stable(rt_count_value))
        else $error("count moved in debug mode");

    // Prescaler off holds the count
    presc_off_a: assert property (rt_prescale_select == 4'h0
        && !restart |=> $stable(rt_count_value))
        else $error("count moved with prescaler off");

    // Deep stop silences the reference clocks
    deep_stop_a: assert property (deep_stop_mode
        && rt_clock_select != CLKS_LPO |-> !pif.src_edge)
        else $error("reference clock counted in deep stop");

    // Count writes are ignored
    count_ro_a: assert property (wr_cnt && !pif.tick
        |=> $stable(rt_count_value))
        else $error("count register took a write");

    // Clear by one, unless a match arrives together
    flag_clear_a: assert property (flag_clear && !match_event
        |=> !rt_match_flag ##0 !rt_irq)
        else $error("flag clear failed");

    // Writing zero to the flag leaves it
    flag_keep_a: assert property (rt_match_flag && wr_sc
        && !hwdata[FLAG_BIT] |=> rt_match_flag)
        else $error("writing zero cleared the flag");

    // Request follows flag and enable
    irq_gate_a: assert property (rt_match_flag && rt_irq_enable
        |-> rt_irq)
        else $error("interrupt request not raised");

    // No request without both flag and enable
    irq_quiet_a: assert property (!rt_match_flag || !rt_irq_enable
        |-> !rt_irq)
        else $error("interrupt request without cause");

    // The flag stays up until software clears it
    flag_hold_a: assert property (rt_match_flag && !flag_clear
        |=> rt_match_flag)
        else $error("flag dropped without a clear");

    // The count moves only on a tick or a restart
    count_idle_a: assert property (!pif.tick && !restart
        |=> $stable(rt_count_value))
        else $error("count moved without a tick");

    // Debug mode lets no prescaler output through
    hold_no_tick_a: assert property (background_mode
        |-> !pif.tick)
        else $error("prescaler ticked in debug mode");

    wrap_c: cover property (match_event && rt_modulo_limit != 8'h00);
    zero_mod_c: cover property (match_event && rt_modulo_limit == 8'h00);
    clear_c: cover property (rt_match_flag ##1 flag_clear ##1
                             !rt_match_flag);
    freeze_c: cover property (background_mode && pif.src_edge);
    irq_c: cover property ($rose(rt_irq));
endmodule

// File: rtc_pkg.sv
/*
 * Shared constants for the periodic real-time counter: register byte
 * offsets, status/control field positions, reset values, source codes
 * and the prescaler divide-ratio lookup.
 * Assumes a 32-bit AHB-Lite slave with one register per aligned word.
 */
package rtc_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNT_VALUE    = 8'h04;
    localparam logic [7:0] OFS_MODULO_LIMIT   = 8'h08;

    // Status/control field positions
    localparam int FLAG_BIT = 7;
    localparam int CLKS_MSB = 6;
    localparam int CLKS_LSB = 5;
    localparam int IE_BIT   = 4;
    localparam int PS_MSB   = 3;
    localparam int PS_LSB   = 0;

    // Reset values
    localparam logic [1:0] CLKS_RESET   = 2'h0;
    localparam logic [3:0] PS_RESET     = 4'h0;
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [7:0] MODULO_RESET = 8'h00;

    // Clock source codes; any code with the top bit set is the 32 kHz source
    localparam logic [1:0] CLKS_LPO = 2'h0;
    localparam logic [1:0] CLKS_EXT = 2'h1;

    // AHB encodings used by the slave
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    localparam int RATIO_W = 18;
    typedef logic [RATIO_W-1:0] ratio_t;

    // Divide ratio from clock-select bit 0 and prescale code; 0 means off
    function automatic ratio_t divide_ratio(input logic       cks0,
                                            input logic [3:0] ps);
        ratio_t r;
        r = '0;
        case ({cks0, ps})
            5'h01: r = 18'h00008;   // 8
            5'h02: r = 18'h00020;   // 32
            5'h03: r = 18'h00040;   // 64
            5'h04: r = 18'h00080;   // 128
            5'h05: r = 18'h00100;   // 256
            5'h06: r = 18'h00200;   // 512
            5'h07: r = 18'h00400;   // 1024
            5'h08: r = 18'h00001;   // 1
            5'h09: r = 18'h00002;   // 2
            5'h0a: r = 18'h00004;   // 4
            5'h0b: r = 18'h0000a;   // 10
            5'h0c: r = 18'h00010;   // 16
            5'h0d: r = 18'h00064;   // 100
            5'h0e: r = 18'h001f4;   // 500
            5'h0f: r = 18'h003e8;   // 1000
            5'h11: r = 18'h00400;   // 1024
            5'h12: r = 18'h00800;   // 2048
            5'h13: r = 18'h01000;   // 4096
            5'h14: r = 18'h02000;   // 8192
            5'h15: r = 18'h04000;   // 16384
            5'h16: r = 18'h08000;   // 32768
            5'h17: r = 18'h10000;   // 65536
            5'h18: r = 18'h003e8;   // 1000
            5'h19: r = 18'h007d0;   // 2000
            5'h1a: r = 18'h01388;   // 5000
            5'h1b: r = 18'h02710;   // 10000
            5'h1c: r = 18'h04e20;   // 20000
            5'h1d: r = 18'h0c350;   // 50000
            5'h1e: r = 18'h186a0;   // 100000
            5'h1f: r = 18'h30d40;   // 200000
            default: r = '0;        // Code 0: prescaler off
        endcase
        return r;
    endfunction

endpackage

// File: presc_if.sv
/*
 * Carrier between the counter core and its prescaler.
 * Assumes both ends run on the same bus clock.
 */
`timescale 1ns/100ps
interface presc_if;
    logic                   src_edge;   // Rising edge of selected source
    logic [17:0]            ratio;      // Divide ratio, 0 = off
    logic                   clear;      // Restart prescaler at zero
    logic                   hold;       // Freeze while debugging
    logic                   tick;       // Prescaler output edge

    modport ctrl (output src_edge, output ratio, output clear,
                  output hold, input tick);
    modport div  (input src_edge, input ratio, input clear,
                  input hold, output tick);
endinterface

// File: rtc_prescaler.sv
/*
 * Prescaler: counts rising edges of the chosen source and emits one
 * tick every ratio edges.
 * Assumes src_edge is a one-cycle pulse in the bus clock domain.
 */
`timescale 1ns/100ps
module rtc_prescaler (
    input  wire logic hclk,
    input  wire logic hresetn,
    presc_if.div      pif
);
    import rtc_pkg::*;

    ratio_t     div_count;
    logic       at_top;

    assign at_top = (div_count == pif.ratio - 18'h1);

    // Output tick; a zero ratio keeps the prescaler off
    assign pif.tick = pif.src_edge & ~pif.hold & (pif.ratio != '0)
                      & at_top;

    // Edge counter, cleared on reconfiguration, held while frozen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_count <= '0;
        end else if (pif.clear) begin
            div_count <= '0;
        end else if (pif.hold || pif.ratio == '0) begin
            div_count <= div_count;
        end else if (pif.src_edge) begin
            div_count <= at_top ? '0 : div_count + 18'h1;
        end
    end

    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Prescaler must hold its position while debug freezes it
    presc_hold_a: assert property (pif.hold && !pif.clear
        |=> $stable(div_count))
        else $error("prescaler moved while frozen");
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the periodic real-time counter: AHB-Lite
 * master tasks and an integer model of prescaler, counter and flag.
 * Assumes the design package and a single slave on the bus.
 */
`timescale 1ns/100ps
module tb_top;
    import rtc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rt_irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [2:0]  src;
    logic        deep_stop_mode, background_mode;
    logic [7:0]  q[$];
    int          err_total, num_checks, cyc, n, s, ratio;
    int          m_cnt, m_pre, m_mod, m_flag, m_ie, m_clks, m_ps;
    int r0[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16,
                   100, 500, 1000};
    int r1[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536, 1000,
                   2000, 5000, 10000, 20000, 50000, 100000, 200000};

    // Single slave, so its ready is the bus ready
    periodic_realtime_counter periodic_realtime_counter_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .low_power_osc_1khz(src[0]),
        .external_ref_clock(src[1]), .internal_ref_clock(src[2]),
        .deep_stop_mode(deep_stop_mode),
        .background_mode(background_mode), .rt_irq(rt_irq));

    // Bus clock, 10 ns period
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Longest path is the every-source-code loop; the ceiling leaves ample margin
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            complete_run;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single transfer; each phase held until ready is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // Write and mirror its side effects in the model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
        if (a == OFS_STATUS_CONTROL) begin
            if (d[7])
                m_flag = 0;
            if (d[6:5] != m_clks[1:0] || d[3:0] != m_ps[3:0]) begin
                m_cnt = 0;
                m_pre = 0;
            end
            m_clks = d[6:5];
            m_ie = d[4];
            m_ps = d[3:0];
        end else if (a == OFS_MODULO_LIMIT) begin
            m_mod = d[7:0];
            m_cnt = 0;
            m_pre = 0;
        end
    endtask

    // Rising edges on one source; the model counts only live edges
    task automatic edges(input int si, input int k);
        repeat (k) begin
            @(posedge hclk) src[si] <= 1'b1;
            @(posedge hclk) src[si] <= 1'b0;
            ratio = m_clks[0] ? r1[m_ps] : r0[m_ps];
            if (ratio != 0 && !background_mode && !(deep_stop_mode && si != 0)
                && ((si == 0 && m_clks == 0) || (si == 1 && m_clks == 1)
                || (si == 2 && m_clks >= 2))) begin
                m_pre++;
                if (m_pre == ratio) begin
                    m_pre = 0;
                    if (m_cnt == m_mod) begin
                        m_cnt = 0;
                        m_flag = 1;
                    end else
                        m_cnt++;
                end
            end
        end
        repeat (4) @(posedge hclk);
    endtask

    // Read all three registers and the request line against the model
    task automatic verify;
        bus(1'b0, OFS_STATUS_CONTROL, 32'h0, rd);
        check(rd, {24'h0, 1'(m_flag), 2'(m_clks), 1'(m_ie), 4'(m_ps)});
        bus(1'b0, OFS_COUNT_VALUE, 32'h0, rd);
        check(rd, 32'(m_cnt));
        bus(1'b0, OFS_MODULO_LIMIT, 32'h0, rd);
        check(rd, 32'(m_mod));
        check({29'h0, hreadyout, hresp, rt_irq},
              {29'h0, 1'b1, 1'b0, 1'(m_flag & m_ie)});
    endtask

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, src} = '0;
        {deep_stop_mode, background_mode} = 2'h0;
        hsize = HSIZE_WORD;
        {err_total, num_checks, cyc, m_cnt, m_pre, m_mod} = '0;
        {m_flag, m_ie, m_clks, m_ps} = '0;
        void'($urandom(98));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        verify;
        // Unmapped place reads zero and swallows writes
        wr(8'h0c, 32'hff);
        bus(1'b0, 8'h0c, 32'h0, rd);
        check(rd, 32'h0);
        // Divide by one, modulo 3: wrap sets the flag, count ignores writes
        wr(OFS_STATUS_CONTROL, 32'h08);
        wr(OFS_MODULO_LIMIT, 32'h03);
        edges(0, 3);
        wr(OFS_COUNT_VALUE, 32'hff);
        verify;
        edges(0, 1);
        verify;
        wr(OFS_STATUS_CONTROL, 32'h18);
        verify;
        wr(OFS_STATUS_CONTROL, 32'h98);
        verify;
        // Modulo zero flags every prescaler output
        wr(OFS_MODULO_LIMIT, 32'h00);
        repeat (2) begin
            edges(0, 1);
            verify;
            wr(OFS_STATUS_CONTROL, 32'h88);
        end
        // Changed prescale code and modulo write both restart counting
        wr(OFS_MODULO_LIMIT, 32'hff);
        edges(0, 2);
        wr(OFS_STATUS_CONTROL, 32'h09);
        verify;
        edges(0, 5);
        wr(OFS_MODULO_LIMIT, 32'hff);
        verify;
        // Every source code against every source
        for (int c = 0; c < 4; c++) begin
            wr(OFS_STATUS_CONTROL, 32'(c << 5) | 32'h08);
            for (int si = 0; si < 3; si++)
                edges(si, c[0] ? 1000 : 1);
            verify;
        end
        // Ratio sweep at the boundary, random edge count around it
        for (int p = 1; p < 16; p++)
            q.push_back(8'(p));
        q.push_back(8'h61);
        foreach (q[i]) begin
            wr(OFS_STATUS_CONTROL, {24'h0, q[i]});
            wr(OFS_MODULO_LIMIT, 32'hff);
            ratio = q[i][5] ? r1[q[i][3:0]] : r0[q[i][3:0]];
            n = ratio - 1 + int'($urandom % 3);
            s = q[i][6] ? 2 : 0;
            edges(s, n);
            verify;
        end
        // Deep stop gates the reference clocks only
        wr(OFS_STATUS_CONTROL, 32'h48);
        @(posedge hclk) deep_stop_mode <= 1'b1;
        edges(2, 3);
        verify;
        wr(OFS_STATUS_CONTROL, 32'h08);
        edges(0, 2);
        verify;
        @(posedge hclk) deep_stop_mode <= 1'b0;
        // Debug freeze holds the count, then resumes from it
        @(posedge hclk) background_mode <= 1'b1;
        edges(0, 3);
        verify;
        @(posedge hclk) background_mode <= 1'b0;
        edges(0, 2);
        verify;
        // Software stops the counter before a low-power spell
        wr(OFS_STATUS_CONTROL, 32'h00);
        edges(0, 3);
        verify;
        // Mid-run reset returns every register to zero
        @(posedge hclk) hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        {m_cnt, m_pre, m_mod, m_flag, m_ie, m_clks, m_ps} = '0;
        verify;
        complete_run;
    end
endmodule
